// >>> bench/lbg_far_end.sv
`timescale 1ns/10ps
// ============================================================
// Far-side model: sinks frame bytes, returns one status per frame
module lbg_far_end (
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    input  wire lbg_pkg::lbg_tx_s tx,
    input  wire logic            slow,
    input  wire logic            bad,
    output logic                 tx_ready,
    output logic                 rx_done,
    output logic                 rx_crc_err,
    output int                   frames,
    output int                   len,
    output logic [7:0]           cap [16]
);
    import lbg_pkg::*;

    int   idx_ff;
    logic take;

    assign take = tx.valid && tx_ready;

    // Half-rate acceptance when slow, so the sender must hold each byte
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    end

    // Keep the head of the latest frame; only 16 bytes, enough for the header
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idx_ff <= 0;
            frames <= 0;
            len    <= 0;
        end else if (take) begin
            if (idx_ff < 16) begin
                cap[idx_ff[3:0]] <= tx.data;
            end
            if (tx.last) begin
                frames <= frames + 1;
                len    <= idx_ff + 1;
                idx_ff <= 0;
            end else begin
                idx_ff <= idx_ff + 1;
            end
        end
    end

    // Error flag toggles between frames so no idle value can be leaned on
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_done    <= 1'b0;
            rx_crc_err <= 1'b0;
        end else begin
            rx_done    <= take && tx.last;
            rx_crc_err <= (take && tx.last) ? bad : ~rx_crc_err;
        end
    end
endmodule // lbg_far_end

// >>> bench/tb_top.sv
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the loop-back frame generator
module tb_top;
    import lbg_pkg::*;

    logic       ref_clk = 1'b0, nrst = 1'b0, center = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
    logic       slow = 1'b0, bad = 1'b0;
    logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, rv;
    lbg_mac_t   sta = {8'h3C, 8'h2B, 8'h1A, 8'h09, 8'hF8, 8'hE7};
    lbg_tx_s    tx;
    logic       txr, rxd, rxe, clr_v, clr_r, irq;
    logic [7:0] cap [16];
    int         frames, len, f0, cyc = 0;
    int         n_errors = 0, total_checks = 0;

    always #20 ref_clk = ~ref_clk;

    lbg_top DUT (.ref_clk(ref_clk), .nrst(nrst), .center_side_pin(center), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .station_addr(sta), .tx(tx), .tx_ready(txr), .rx_done(rxd), .rx_crc_err(rxe),
        .clr_valid_counters(clr_v), .clr_result_counters(clr_r), .irq(irq));

    lbg_far_end lp (.ref_clk(ref_clk), .nrst(nrst), .tx(tx), .slow(slow), .bad(bad), .tx_ready(txr),
        .rx_done(rxd), .rx_crc_err(rxe), .frames(frames), .len(len), .cap(cap));

    // ============================================================
    // Shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge ref_clk);
        bus_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic br(input logic [7:0] a);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge ref_clk);
        bus_rd   <= 1'b0;
        #1 rv = bus_rdata;
    endtask

    // Poll busy with a ceiling so a stuck burst cannot hang the run
    task automatic idle();
        for (int i = 0; i < 8000; i++) begin
            br(LBG_OFS_BURST);
            if (rv[7] === 1'b0) break;
        end
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        br(LBG_OFS_COUNT);   chk(rv, 8'h07, "count reset");
        br(LBG_OFS_PATTERN); chk(rv, 8'h00, "pattern reset");
        bw(LBG_OFS_PATTERN, 8'h40);
        br(LBG_OFS_PATTERN); chk(rv, 8'h40, "pattern rw");
        bw(LBG_OFS_CRC_ERR, 8'h5A);
        br(LBG_OFS_CRC_ERR); chk(rv, 8'h00, "tally read only");
        br(8'h70);           chk(rv, 8'h00, "unmapped read");
    endtask

    // Every defined pattern code, one frame each, header and payload judged
    task automatic t_patterns();
        logic [7:0]  codes [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
        logic [7:0]  c;
        logic        bc, lg;
        logic [15:0] pat;
        for (int k = 0; k < 9; k++) begin
            c   = codes[k];
            bc  = c inside {8'h02, 8'h04, 8'h20, 8'h40, 8'h80};
            lg  = c inside {8'h01, 8'h04, 8'h10, 8'h40, 8'h80};
            pat = (c == 8'h80) ? 16'hFF00 : ((c >= 8'h08) ? 16'h0F0F : 16'h55AA);
            f0  = frames;
            bw(LBG_OFS_PATTERN, c);
            bw(LBG_OFS_COUNT, 8'h01);
            idle();
            chk(16'(frames - f0), 16'd1, "one frame");
            chk(16'(len), lg ? 16'd1514 : 16'd60, "frame length");
            chk(cap[0], bc ? 8'hFF : sta[0], "dest first");
            chk(cap[5], bc ? 8'hFF : 8'(sta[5] + 8'h01), "dest last");
            chk(cap[6], sta[0], "source first");
            chk(cap[11], sta[5], "source last");
            chk({cap[12], cap[13]}, 16'h0800, "type field");
            chk({cap[14], cap[15]}, pat, "payload");
        end
    endtask

    // Stalled burst of three, destination step and done interrupt
    task automatic t_burst_irq();
        bw(LBG_OFS_PATTERN, 8'h00);
        bw(LBG_OFS_IRQ_MASK, 8'h01);
        bw(LBG_OFS_IRQ_STAT, 8'h03);
        slow <= 1'b1;
        f0 = frames;
        bw(LBG_OFS_COUNT, 8'h03);
        #1 chk(tx.valid, 1'b1, "burst starts");
        idle();
        slow <= 1'b0;
        chk(16'(frames - f0), 16'd3, "three frames");
        chk(cap[5], 8'(sta[5] + 8'h03), "dest step");
        chk(irq, 1'b1, "irq raised");
        br(LBG_OFS_IRQ_STAT); chk(rv[1:0], 2'b01, "done status");
        bw(LBG_OFS_IRQ_STAT, 8'h01);
        br(LBG_OFS_IRQ_STAT); chk(rv[1:0], 2'b00, "status cleared");
        chk(irq, 1'b0, "irq dropped");
    endtask

    // Errored returns: count, saturate, clear, then an aborted burst
    task automatic t_tally();
        bw(LBG_OFS_IRQ_MASK, 8'h00);
        bad <= 1'b1;
        bw(LBG_OFS_COUNT, 8'h64);
        idle();
        br(LBG_OFS_CRC_ERR); chk(rv, 8'h64, "tally counts");
        br(LBG_OFS_IRQ_STAT); chk(rv[1], 1'b1, "crc status");
        chk(irq, 1'b0, "irq masked");
        for (int i = 0; i < 2; i++) begin
            bw(LBG_OFS_COUNT, 8'h64);
            idle();
        end
        br(LBG_OFS_CRC_ERR); chk(rv, 8'hFF, "tally saturates");
        bad <= 1'b0;
        bw(LBG_OFS_COUNT, 8'h00);
        #1 chk(clr_v, 1'b1, "valid clear");
        chk(clr_r, 1'b1, "result clear");
        br(LBG_OFS_CRC_ERR); chk(rv, 8'h00, "tally cleared");
        f0 = frames;
        bw(LBG_OFS_COUNT, 8'h02);
        bw(LBG_OFS_COUNT, 8'h00);
        repeat (100) @(posedge ref_clk);
        chk(16'(frames - f0), 16'd0, "aborted burst idle");
    endtask

    // Terminal strap: no burst, valid counters clear, results untouched
    task automatic t_terminal();
        center <= 1'b0;
        repeat (4) @(posedge ref_clk);
        f0 = frames;
        bw(LBG_OFS_COUNT, 8'h05);
        repeat (100) @(posedge ref_clk);
        chk(16'(frames - f0), 16'd0, "terminal no burst");
        bw(LBG_OFS_COUNT, 8'h00);
        #1 chk(clr_v, 1'b1, "terminal valid clear");
        chk(clr_r, 1'b0, "terminal keeps results");
        center <= 1'b1;
    endtask

    // ============================================================
    // Hang guard, sized well above the expected 27k cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_patterns();
        t_burst_irq();
        t_tally();
        t_terminal();
        wrap_up();
    end
endmodule // tb_top

// >>> core/lbg_top.sv
`timescale 1ns/10ps
module lbg_top (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              center_side_pin,
    input  wire logic [7:0]        bus_addr,
    input  wire logic [7:0]        bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic [7:0]             bus_rdata,
    input  wire lbg_pkg::lbg_mac_t station_addr,
    output lbg_pkg::lbg_tx_s       tx,
    input  wire logic              tx_ready,
    input  wire logic              rx_done,
    input  wire logic              rx_crc_err,
    output logic                   clr_valid_counters,
    output logic                   clr_result_counters,
    output logic                   irq
);
    import lbg_pkg::*;

    default clocking lbg_cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Decode helpers

    // Unknown codes fall back to the first code's frame shape
    function automatic lbg_cfg_s decode_pattern(input logic [7:0] code);
        lbg_cfg_s c;
        c = '{long_frame: 1'b0, bcast: 1'b0, pat_hi: 8'h55, pat_lo: 8'hAA};
        case (code)
            8'h01: c.long_frame = 1'b1;
            8'h02: c.bcast = 1'b1;
            8'h04: c = '{1'b1, 1'b1, 8'h55, 8'hAA};
            8'h08: c = '{1'b0, 1'b0, 8'h0F, 8'h0F};
            8'h10: c = '{1'b1, 1'b0, 8'h0F, 8'h0F};
            8'h20: c = '{1'b0, 1'b1, 8'h0F, 8'h0F};
            8'h40: c = '{1'b1, 1'b1, 8'h0F, 8'h0F};
            8'h80: c = '{1'b1, 1'b1, 8'hFF, 8'h00};
            default: c = c;
        endcase
        return c;
    endfunction

    // Register writes are decoded in several places; strobe and address are arguments so assigns track them
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
        return wr && (addr == ofs);
    endfunction

    // ==========================================================
    // Strap synchroniser, the side select is a pin
    logic cs_meta_ff;
    logic center_ff;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cs_meta_ff <= 1'b0;
            center_ff  <= 1'b0;
        end else begin
            cs_meta_ff <= center_side_pin;
            center_ff  <= cs_meta_ff;
        end
    end

    // ==========================================================
    // Software registers
    logic [7:0]          count_ff;
    logic [7:0]          pattern_ff;
    logic [LBG_IRQ_W-1:0] mask_ff;
    logic                wr_count;
    logic                wr_zero;
    logic                wr_start;

    assign wr_count = wr_hit(bus_wr, bus_addr, LBG_OFS_COUNT);
    assign wr_zero  = wr_count && (bus_wdata == LBG_COUNT_CLEAR);
    // Out-of-range counts are stored but never start a burst
    assign wr_start = wr_count && center_ff && !wr_zero && (bus_wdata <= LBG_COUNT_MAX);

    // Count, pattern and mask storage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_ff   <= LBG_COUNT_RST;
            pattern_ff <= LBG_PATTERN_RST;
            mask_ff    <= '0;
        end else begin
            if (wr_count)
                count_ff <= bus_wdata;
            if (wr_hit(bus_wr, bus_addr, LBG_OFS_PATTERN))
                pattern_ff <= bus_wdata;
            if (wr_hit(bus_wr, bus_addr, LBG_OFS_IRQ_MASK))
                mask_ff <= bus_wdata[LBG_IRQ_W-1:0];
        end
    end

    // Clear pulses towards the counters kept elsewhere
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clr_valid_counters  <= 1'b0;
            clr_result_counters <= 1'b0;
        end else begin
            clr_valid_counters  <= wr_zero;
            clr_result_counters <= wr_zero && center_ff;
        end
    end

    clear_valid_a: assert property (
        wr_zero |=> clr_valid_counters ##1 !clr_valid_counters || $past(wr_zero))
        else $error("valid counter clear not pulsed");

    clear_result_a: assert property (
        clr_result_counters |-> $past(wr_zero) && $past(center_ff))
        else $error("result clear without a zero write");

    count_store_a: assert property (
        wr_count |=> count_ff == $past(bus_wdata))
        else $error("frame count not stored");

    pattern_store_a: assert property (
        bus_wr && bus_addr == LBG_OFS_PATTERN |=> pattern_ff == $past(bus_wdata))
        else $error("pattern select not stored");

    // ==========================================================
    // Errored frame tally
    logic [7:0] tally_ff;
    logic       crc_evt;

    assign crc_evt = rx_done && rx_crc_err && center_ff;

    // An error in the clearing cycle still counts once
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tally_ff <= '0;
        end else if (wr_zero && center_ff) begin
            tally_ff <= crc_evt ? 8'h01 : 8'h00;
        end else if (crc_evt && tally_ff != LBG_TALLY_MAX) begin
            tally_ff <= tally_ff + 8'h01;
        end
    end

    tally_clear_a: assert property (
        wr_zero && center_ff && !crc_evt |=> tally_ff == 8'h00)
        else $error("error tally not cleared");

    tally_step_a: assert property (
        crc_evt && !wr_zero && tally_ff != LBG_TALLY_MAX |=> tally_ff == $past(tally_ff) + 8'h01)
        else $error("error tally did not step");

    tally_hold_a: assert property (
        tally_ff == LBG_TALLY_MAX && !wr_zero |=> tally_ff == LBG_TALLY_MAX)
        else $error("error tally wrapped");

    tally_quiet_a: assert property (
        !crc_evt && !wr_zero |=> $stable(tally_ff))
        else $error("error tally moved without cause");

    tally_term_a: assert property (
        !center_ff |=> $stable(tally_ff))
        else $error("error tally moved on terminal side");

    // ==========================================================
    // Frame generator
    lbg_state_e  state_ff;
    lbg_cfg_s    cfg_ff;
    logic [6:0]  remain_ff;
    logic [7:0]  da_last_ff;
    logic [10:0] idx_ff;
    logic [10:0] last_idx;
    logic        tx_take;
    logic        frame_end;
    logic        burst_done;

    assign last_idx   = cfg_ff.long_frame ? LBG_LAST_LONG : LBG_LAST_SHORT;
    assign tx_take    = tx.valid && tx_ready;
    assign frame_end  = tx_take && tx.last;
    assign burst_done = frame_end && (remain_ff == 7'h01) && !wr_start && !wr_zero;

    // Byte of the frame at a given index, FCS is appended downstream
    function automatic logic [7:0] frame_byte(input logic [10:0] i, input logic [7:0] da_last,
                                              input lbg_cfg_s c, input lbg_mac_t sa);
        logic [7:0] b;
        b = 8'h00;
        if (i < LBG_IDX_DA_LAST)
            b = c.bcast ? LBG_BCAST_BYTE : sa[i[2:0]];
        else if (i == LBG_IDX_DA_LAST)
            b = c.bcast ? LBG_BCAST_BYTE : da_last;
        else if (i < LBG_IDX_TYPE_HI)
            b = sa[3'(i - LBG_IDX_SA)];
        else if (i == LBG_IDX_TYPE_HI)
            b = LBG_TYPE_HI;
        else if (i == LBG_IDX_TYPE_LO)
            b = LBG_TYPE_LO;
        else
            b = i[0] ? c.pat_lo : c.pat_hi;
        return b;
    endfunction

    // Sequencer; a new count write from 1 to 100 on the Center side restarts, zero aborts
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff   <= LBG_ST_IDLE;
            cfg_ff     <= '0;
            remain_ff  <= '0;
            da_last_ff <= '0;
            idx_ff     <= '0;
        end else if (wr_start) begin
            state_ff   <= LBG_ST_SEND;
            cfg_ff     <= decode_pattern(pattern_ff);
            remain_ff  <= bus_wdata[6:0];
            da_last_ff <= station_addr[5] + 8'h01;
            idx_ff     <= '0;
        end else if (wr_zero) begin
            state_ff  <= LBG_ST_IDLE;
            remain_ff <= '0;
        end else begin
            case (state_ff)
                LBG_ST_IDLE: begin
                    idx_ff <= '0;
                end
                LBG_ST_SEND: begin
                    if (frame_end) begin
                        remain_ff  <= remain_ff - 7'h01;
                        da_last_ff <= da_last_ff + 8'h01;
                        idx_ff     <= '0;
                        if (remain_ff == 7'h01)
                            state_ff <= LBG_ST_IDLE;
                    end else if (tx_take) begin
                        idx_ff <= idx_ff + 11'h001;
                    end
                end
                default: begin
                    state_ff <= LBG_ST_IDLE;
                end
            endcase
        end
    end

    // First byte of a burst, built from the pattern that stands at the start write
    logic [7:0] start_byte;
    assign start_byte = frame_byte('0, station_addr[5] + 8'h01, decode_pattern(pattern_ff), station_addr);

    // Output byte register; the next byte loads only when the sink took the current one
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx <= '0;
        end else if (wr_start) begin
            tx <= '{valid: 1'b1, last: 1'b0, data: start_byte};
        end else if (wr_zero || burst_done || state_ff != LBG_ST_SEND) begin
            tx <= '0;
        end else if (frame_end) begin
            tx <= '{valid: 1'b1, last: 1'b0, data: frame_byte('0, da_last_ff + 8'h01, cfg_ff, station_addr)};
        end else if (tx_take) begin
            tx.last <= (idx_ff + 11'h001) == last_idx;
            tx.data <= frame_byte(idx_ff + 11'h001, da_last_ff, cfg_ff, station_addr);
        end
    end

    // Reference byte for the current index; the registered port byte must match it
    logic [7:0] cur_byte;
    assign cur_byte = frame_byte(idx_ff, da_last_ff, cfg_ff, station_addr);

    type_field_a: assert property (
        tx.valid && idx_ff == LBG_IDX_TYPE_HI |-> tx.data == LBG_TYPE_HI)
        else $error("type field high byte wrong");

    type_low_a: assert property (
        tx.valid && idx_ff == LBG_IDX_TYPE_LO |-> tx.data == LBG_TYPE_LO)
        else $error("type field low byte wrong");

    da_step_a: assert property (
        frame_end && remain_ff > 7'h01 && !wr_start && !wr_zero |=> da_last_ff == $past(da_last_ff) + 8'h01)
        else $error("destination byte did not step");

    burst_len_a: assert property (
        wr_start |=> remain_ff == $past(bus_wdata[6:0]) && state_ff == LBG_ST_SEND && tx.valid)
        else $error("burst not loaded");

    frame_len_a: assert property (
        tx.valid |-> tx.last == (idx_ff == last_idx))
        else $error("frame length wrong");

    sa_plain_a: assert property (
        tx.valid && idx_ff >= LBG_IDX_SA && idx_ff < LBG_IDX_TYPE_HI
        |-> tx.data == station_addr[3'(idx_ff - LBG_IDX_SA)])
        else $error("source address wrong");

    data_align_a: assert property (
        tx.valid |-> tx.data == cur_byte)
        else $error("frame byte out of step");

    start_byte_a: assert property (
        wr_start |=> tx.data == (cfg_ff.bcast ? LBG_BCAST_BYTE : station_addr[0]))
        else $error("first byte of burst wrong");

    da_last_a: assert property (
        tx.valid && idx_ff == LBG_IDX_DA_LAST && !cfg_ff.bcast |-> tx.data == da_last_ff)
        else $error("destination last byte wrong");

    bcast_da_a: assert property (
        tx.valid && cfg_ff.bcast && idx_ff <= LBG_IDX_DA_LAST |-> tx.data == LBG_BCAST_BYTE)
        else $error("broadcast destination wrong");

    payload_a: assert property (
        tx.valid && idx_ff >= LBG_IDX_PAYLOAD |-> tx.data == (idx_ff[0] ? cfg_ff.pat_lo : cfg_ff.pat_hi))
        else $error("payload byte wrong");

    burst_stop_a: assert property (
        burst_done |=> !tx.valid && state_ff == LBG_ST_IDLE && remain_ff == 7'h00)
        else $error("burst ran past its count");

    zero_abort_a: assert property (
        wr_zero |=> !tx.valid && state_ff == LBG_ST_IDLE)
        else $error("zero write did not stop the burst");

    // ==========================================================
    // Interrupt status, write one to clear, a new event wins
    logic [LBG_IRQ_W-1:0] stat_ff;
    logic [LBG_IRQ_W-1:0] stat_set;
    logic [LBG_IRQ_W-1:0] stat_clr;

    assign stat_set = {crc_evt, burst_done};
    assign stat_clr = wr_hit(bus_wr, bus_addr, LBG_OFS_IRQ_STAT) ? bus_wdata[LBG_IRQ_W-1:0] : '0;

    // Sticky events
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            stat_ff <= '0;
        else
            stat_ff <= (stat_ff & ~stat_clr) | stat_set;
    end

    // Level interrupt from the masked status
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(((stat_ff & ~stat_clr) | stat_set) & mask_ff);
    end

    irq_level_a: assert property (
        irq == |($past(((stat_ff & ~stat_clr) | stat_set)) & $past(mask_ff)))
        else $error("interrupt level wrong");

    irq_done_a: assert property (
        burst_done |=> stat_ff[LBG_IRQ_DONE])
        else $error("burst done status not set");

    stat_sticky_a: assert property (
        stat_ff[LBG_IRQ_CRC] && !stat_clr[LBG_IRQ_CRC] |=> stat_ff[LBG_IRQ_CRC])
        else $error("error status not sticky");

    // ==========================================================
    // Read port, data valid the cycle after the strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= '0;
        end else if (bus_rd) begin
            case (bus_addr)
                LBG_OFS_COUNT:    bus_rdata <= count_ff;
                LBG_OFS_PATTERN:  bus_rdata <= pattern_ff;
                LBG_OFS_CRC_ERR:  bus_rdata <= tally_ff;
                LBG_OFS_IRQ_STAT: bus_rdata <= 8'(stat_ff);
                LBG_OFS_IRQ_MASK: bus_rdata <= 8'(mask_ff);
                LBG_OFS_BURST:    bus_rdata <= {state_ff == LBG_ST_SEND, remain_ff};
                default:          bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    rdata_idle_a: assert property (
        !bus_rd |=> bus_rdata == 8'h00)
        else $error("read data outside its cycle");

endmodule // lbg_top

// >>> shared/lbg_pkg.sv
// Notes on behaviour
// - Writing zero to frame count clears valid transmit and receive counters.
// - On Center side, writing zero also clears all three loop-back result counters.
// - On Center side, writing N from 1 to 100 sends exactly N test frames.
// - Frame count register resets to seven.
// - Center side has an 8-bit read-write pattern select register, reset zero.
// - Codes 00,01,02,04 give 55AA frames: 64/1518 unicast, 64/1518 broadcast.
// - Codes 08,10,20,40 give 0F0F frames: 64/1518 unicast, 64/1518 broadcast.
// - Code 80 gives 1518-byte broadcast FF00; only nine codes are used.
// - Destination takes five address bytes, last byte is address byte six plus one.
// - Last destination byte steps by one for each following frame of a burst.
// - Source address is the six address bytes without any increment.
// - Every test frame carries type/length 0x0800.
// - Read-only 8-bit counter counts returned frames with CRC error.
// - CRC error counter clears when zero is written to frame count.
package lbg_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] LBG_OFS_COUNT    = 8'h44;
    localparam logic [7:0] LBG_OFS_PATTERN  = 8'h45;
    localparam logic [7:0] LBG_OFS_CRC_ERR  = 8'h46;
    localparam logic [7:0] LBG_OFS_IRQ_STAT = 8'h60;
    localparam logic [7:0] LBG_OFS_IRQ_MASK = 8'h61;
    localparam logic [7:0] LBG_OFS_BURST    = 8'h62;

    localparam logic [7:0] LBG_COUNT_RST    = 8'h07;
    localparam logic [7:0] LBG_PATTERN_RST  = 8'h00;
    localparam logic [7:0] LBG_COUNT_CLEAR  = 8'h00;
    localparam logic [7:0] LBG_COUNT_MAX    = 8'h64;
    localparam logic [7:0] LBG_TALLY_MAX    = 8'hFF;

    // Interrupt bits: burst finished, errored frame returned
    localparam int LBG_IRQ_DONE = 0;
    localparam int LBG_IRQ_CRC  = 1;
    localparam int LBG_IRQ_W    = 2;

    // ==========================================================
    // Frame layout, byte indices before the FCS
    localparam logic [10:0] LBG_IDX_DA_LAST = 11'h005;
    localparam logic [10:0] LBG_IDX_SA      = 11'h006;
    localparam logic [10:0] LBG_IDX_TYPE_HI = 11'h00C;
    localparam logic [10:0] LBG_IDX_TYPE_LO = 11'h00D;
    localparam logic [10:0] LBG_IDX_PAYLOAD = 11'h00E;
    localparam logic [10:0] LBG_LAST_SHORT  = 11'h03B; // 64 - 4 FCS - 1
    localparam logic [10:0] LBG_LAST_LONG   = 11'h5E9; // 1518 - 4 FCS - 1
    localparam logic [7:0]  LBG_TYPE_HI     = 8'h08;
    localparam logic [7:0]  LBG_TYPE_LO     = 8'h00;
    localparam logic [7:0]  LBG_BCAST_BYTE  = 8'hFF;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        LBG_ST_IDLE = 2'b01,
        LBG_ST_SEND = 2'b10
    } lbg_state_e;

    typedef logic [5:0][7:0] lbg_mac_t;

    typedef struct packed {
        logic       long_frame;
        logic       bcast;
        logic [7:0] pat_hi;
        logic [7:0] pat_lo;
    } lbg_cfg_s;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } lbg_tx_s;

endpackage
